// >>> verilog/klw_pkg.sv
// constants for the key locked watchdog: register map, keys, fields, resets
// assumes a 32-bit apb slave and a 12-bit down counter
// Function
// - key 0xCCCC starts the counter
// - 0x5A5A then 0xA5A5 stops the counter
// - key 0x5555 unlocks protected registers
// - any other key relocks protected registers
// - key 0xAAAA copies reload into counter
// - protected writes ignored until watchdog started
// - control bit 5 freezes counting in deep sleep
// - control bit 4 gates the interrupt output
// - control bit 3 picks reset or interrupt
// - bits 2:0 divide oscillator by 4 shl code
// - control changes only unlocked and not busy
// - reload 12 bits, reset 0xFFF, guarded writes
// - count register shows live counter, read only
// - window register 12 bits, protected, reset 0xFFF
// - start counts down from 0xFFF at prescaled rate
// - zero overflows, reloads, resets or interrupts
// - early refresh resets; window write reloads counter
// - status bits: pending, run, expiry, three busy
package klw_pkg;
  localparam int          DATA_W       = 32;
  localparam int          ADDR_W       = 8;
  localparam int          CNT_W        = 12;
  localparam int          SEL_W        = 3;
  localparam int          DIV_W        = 10;
  localparam int          KEY_W        = 16;

  localparam logic [ADDR_W-1:0] OFS_KEY    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_WINDOW = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h24;

  localparam logic [KEY_W-1:0] KEY_START   = 16'hcccc;
  localparam logic [KEY_W-1:0] KEY_REFRESH = 16'haaaa;
  localparam logic [KEY_W-1:0] KEY_UNLOCK  = 16'h5555;
  localparam logic [KEY_W-1:0] KEY_STOP1   = 16'h5a5a;
  localparam logic [KEY_W-1:0] KEY_STOP2   = 16'ha5a5;

  localparam int CTL_HOLD   = 5;
  localparam int CTL_IRQEN  = 4;
  localparam int CTL_ACTION = 3;
  localparam int CTL_SEL_HI = 2;
  localparam int CTL_W      = 6;

  localparam int ST_PEND  = 5;
  localparam int ST_RUN   = 4;
  localparam int ST_EXP   = 3;
  localparam int ST_WBUSY = 2;
  localparam int ST_RBUSY = 1;
  localparam int ST_CBUSY = 0;

  localparam logic [CTL_W-1:0] CTRL_RST  = 6'h00;
  localparam logic [CNT_W-1:0] CNT_FULL  = 12'hfff;
  localparam logic [DIV_W-1:0] DIV_BASE  = 10'h004;
endpackage

// >>> verilog/klw_tick_if.sv
// carries oscillator edge, prescaled tick and prescaler control between modules
// assumes both ends run on pclk
interface klw_tick_if;
  import klw_pkg::*;
  logic             osc_edge;
  logic             cnt_tick;
  logic             run_enable;
  logic [SEL_W-1:0] divider_select;

  modport prescaler (output osc_edge, output cnt_tick, input run_enable, input divider_select);
  modport core      (input osc_edge, input cnt_tick, output run_enable, output divider_select);
endinterface

// >>> verilog/klw_prescaler.sv
// oscillator pin sampler and programmable prescaler
// assumes the low speed oscillator is far slower than pclk
module klw_prescaler (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                low_speed_osc,
  klw_tick_if.prescaler            tick
);
  import klw_pkg::*;

  logic             osc_meta;
  logic             osc_sync;
  logic             osc_prev;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] div_limit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= low_speed_osc;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  assign tick.osc_edge = osc_sync & ~osc_prev;
  assign div_limit     = (DIV_BASE << tick.divider_select) - DIV_BASE + DIV_W'(3);

  // counting stops while held; divider keeps its phase so resume is seamless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (!tick.run_enable) begin
      div_cnt <= div_cnt;
    end else if (tick.osc_edge) begin
      div_cnt <= (div_cnt >= div_limit) ? '0 : div_cnt + DIV_W'(1);
    end
  end

  assign tick.cnt_tick = tick.run_enable & tick.osc_edge & (div_cnt >= div_limit);

  // a lowered divide code can leave div_cnt above the limit; the tick must still wrap it
  a_div_ratio : assert property (@(posedge pclk) disable iff (!presetn)
    tick.cnt_tick |=> div_cnt == '0)
    else $error("prescale counter did not wrap after tick");
endmodule

// >>> verilog/klw_watchdog.sv
// key locked watchdog: apb register file, key commands, 12-bit down counter
// assumes deep_sleep is a synchronous level, osc pin resynced in the prescaler, pready answered at once
module klw_watchdog #(
  parameter int CNT_W = 12
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [klw_pkg::ADDR_W-1:0] paddr,
  input  wire logic [klw_pkg::DATA_W-1:0] pwdata,
  output logic      [klw_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      low_speed_osc,
  input  wire logic                      deep_sleep,
  output logic                           sys_reset_req,
  output logic                           wdt_irq
);
  import klw_pkg::*;

  klw_tick_if tick ();

  klw_prescaler u_prescaler (
    .pclk          (pclk),
    .presetn       (presetn),
    .low_speed_osc (low_speed_osc),
    .tick          (tick)
  );

  logic             wr_acc;
  logic             rd_setup;
  logic             mapped;
  logic             key_wr;
  logic [KEY_W-1:0] key_field;
  logic             is_start;
  logic             is_refresh;
  logic             is_stop2;
  logic             guard_ok;
  logic             ctl_wr_ok;
  logic             rel_wr_ok;
  logic             win_wr_ok;
  logic             early_refresh;

  logic             running;
  logic             unlocked;
  logic             stop_armed;
  logic [CTL_W-1:0] control;
  logic [CNT_W-1:0] reload_value;
  logic [CNT_W-1:0] window_value;
  logic [CNT_W-1:0] count_value;
  logic             ctl_busy;
  logic             rel_busy;
  logic             win_busy;
  logic             reload_pending;
  logic             expiry_flag;
  logic             overflow;
  logic [DATA_W-1:0] next_prdata;

  // bus decode; zero wait states
  assign pready   = 1'b1;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    if (paddr == OFS_KEY || paddr == OFS_CTRL || paddr == OFS_RELOAD) begin
      mapped = 1'b1;
    end else if (paddr == OFS_STATUS || paddr == OFS_WINDOW || paddr == OFS_COUNT) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr   = psel & penable & ~mapped;
  assign key_wr    = wr_acc & (paddr == OFS_KEY);
  assign key_field = pwdata[KEY_W-1:0];
  assign is_start  = key_wr & (key_field == KEY_START);
  assign is_refresh = key_wr & (key_field == KEY_REFRESH) & running;
  assign is_stop2  = key_wr & (key_field == KEY_STOP2) & stop_armed;

  // protected writes need a started, unlocked watchdog
  assign guard_ok  = running & unlocked;
  assign ctl_wr_ok = wr_acc & (paddr == OFS_CTRL) & guard_ok & ~ctl_busy;
  assign rel_wr_ok = wr_acc & (paddr == OFS_RELOAD) & guard_ok & ~rel_busy;
  assign win_wr_ok = wr_acc & (paddr == OFS_WINDOW) & guard_ok & ~win_busy;

  // default window of all ones can never be exceeded, so the check is off
  assign early_refresh = is_refresh & (count_value > window_value);

  assign overflow = running & tick.cnt_tick & (count_value == '0);

  assign tick.run_enable     = running & ~(control[CTL_HOLD] & deep_sleep);
  assign tick.divider_select = control[CTL_SEL_HI:0];

  // any key except unlock relocks, including start, refresh and stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked <= 1'b0;
    end else if (key_wr) begin
      unlocked <= (key_field == KEY_UNLOCK);
    end
  end

  // stop needs the two keys back to back with no other key between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_armed <= 1'b0;
    end else if (key_wr) begin
      stop_armed <= (key_field == KEY_STOP1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
    end else if (is_start) begin
      running <= 1'b1;
    end else if (is_stop2) begin
      running <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= CTRL_RST;
    end else if (ctl_wr_ok) begin
      control <= pwdata[CTL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_value <= CNT_FULL;
    end else if (rel_wr_ok) begin
      reload_value <= pwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_value <= CNT_FULL;
    end else if (win_wr_ok) begin
      window_value <= pwdata[CNT_W-1:0];
    end
  end

  // busy holds until the oscillator domain has seen the update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_busy <= 1'b0;
      rel_busy <= 1'b0;
      win_busy <= 1'b0;
    end else begin
      ctl_busy <= ctl_wr_ok | (ctl_busy & ~tick.osc_edge);
      rel_busy <= rel_wr_ok | (rel_busy & ~tick.osc_edge);
      win_busy <= win_wr_ok | (win_busy & ~tick.osc_edge);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_pending <= 1'b0;
    end else begin
      reload_pending <= is_refresh | win_wr_ok | (reload_pending & ~tick.osc_edge);
    end
  end

  // refresh and window write take priority over a tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= CNT_FULL;
    end else if (is_start && !running) begin
      count_value <= CNT_FULL;
    end else if (is_refresh || win_wr_ok) begin
      count_value <= reload_value;
    end else if (overflow) begin
      count_value <= reload_value;
    end else if (running && tick.cnt_tick) begin
      count_value <= count_value - CNT_W'(1);
    end
  end

  // sticky expiry: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expiry_flag <= 1'b0;
    end else if (overflow) begin
      expiry_flag <= 1'b1;
    end else if (wr_acc && paddr == OFS_STATUS && !pwdata[ST_EXP]) begin
      expiry_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= (overflow & ~control[CTL_ACTION]) | early_refresh;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_irq <= 1'b0;
    end else begin
      wdt_irq <= expiry_flag & control[CTL_ACTION] & control[CTL_IRQEN];
    end
  end

  always_comb begin
    next_prdata = '0;
    if (paddr == OFS_CTRL) begin
      next_prdata[CTL_W-1:0] = control;
    end else if (paddr == OFS_RELOAD) begin
      next_prdata[CNT_W-1:0] = reload_value;
    end else if (paddr == OFS_STATUS) begin
      next_prdata[ST_PEND]  = reload_pending;
      next_prdata[ST_RUN]   = running;
      next_prdata[ST_EXP]   = expiry_flag;
      next_prdata[ST_WBUSY] = win_busy;
      next_prdata[ST_RBUSY] = rel_busy;
      next_prdata[ST_CBUSY] = ctl_busy;
    end else if (paddr == OFS_WINDOW) begin
      next_prdata[CNT_W-1:0] = window_value;
    end else if (paddr == OFS_COUNT) begin
      next_prdata[CNT_W-1:0] = count_value;
    end
  end

  // read data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  sequence s_key(logic [KEY_W-1:0] val, logic cond);
    key_wr && key_field == val && cond;
  endsequence

  // armed flag spans any number of non-key accesses between the two keys
  sequence s_stop_pair;
    s_key(KEY_STOP2, stop_armed);
  endsequence

  a_start_runs : assert property (@(posedge pclk) disable iff (!presetn)
    s_key(KEY_START, !running) |=> running && count_value == CNT_FULL)
    else $error("start key did not run counter from full");

  a_stop_arm : assert property (@(posedge pclk) disable iff (!presetn)
    s_key(KEY_STOP1, 1'b1) |=> stop_armed)
    else $error("first stop key did not arm stop");

  a_stop_pair : assert property (@(posedge pclk) disable iff (!presetn)
    s_stop_pair |=> !running)
    else $error("stop key pair did not stop counter");

  a_lone_stop : assert property (@(posedge pclk) disable iff (!presetn)
    s_key(KEY_STOP2, !stop_armed && running) |=> running)
    else $error("unpaired stop key stopped counter");

  a_unlock_key : assert property (@(posedge pclk) disable iff (!presetn)
    s_key(KEY_UNLOCK, 1'b1) |=> unlocked)
    else $error("unlock key left registers locked");

  a_relock_key : assert property (@(posedge pclk) disable iff (!presetn)
    key_wr && key_field != KEY_UNLOCK |=> !unlocked)
    else $error("other key did not relock");

  a_refresh_load : assert property (@(posedge pclk) disable iff (!presetn)
    s_key(KEY_REFRESH, running) |=> count_value == $past(reload_value) && reload_pending)
    else $error("refresh did not load reload value");

  a_early_locked : assert property (@(posedge pclk) disable iff (!presetn)
    !running |=> $stable(control) && $stable(reload_value) && $stable(window_value))
    else $error("protected register changed before start");

  a_hold_freeze : assert property (@(posedge pclk) disable iff (!presetn)
    running && deep_sleep && control[CTL_HOLD] && !wr_acc |=> $stable(count_value))
    else $error("counter moved while held in deep sleep");

  a_irq_gate : assert property (@(posedge pclk) disable iff (!presetn)
    !control[CTL_IRQEN] ##1 !control[CTL_IRQEN] |-> !wdt_irq)
    else $error("interrupt raised while disabled");

  a_expiry_reset : assert property (@(posedge pclk) disable iff (!presetn)
    overflow && !is_refresh && !win_wr_ok
    |=> expiry_flag && count_value == $past(reload_value)
        && sys_reset_req == !$past(control[CTL_ACTION]))
    else $error("overflow mishandled");

  a_window_trip : assert property (@(posedge pclk) disable iff (!presetn)
    is_refresh && count_value > window_value |=> sys_reset_req)
    else $error("early refresh did not reset");

  a_busy_hold : assert property (@(posedge pclk) disable iff (!presetn)
    ctl_wr_ok ##1 !tick.osc_edge |-> ctl_busy ##1 ctl_busy)
    else $error("control busy dropped before oscillator edge");

  a_busy_block : assert property (@(posedge pclk) disable iff (!presetn)
    ctl_busy && !tick.osc_edge |=> $stable(control))
    else $error("control changed while busy");
endmodule

// >>> bench/klw_tb.sv
// self-checking bench for the key locked watchdog top module
// assumes a zero wait state apb slave; oscillator made here, 8 pclk per period
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import klw_pkg::*;
  logic              pclk = 0;
  logic              presetn = 0;
  logic              psel = 0;
  logic              penable = 0;
  logic              pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              low_speed_osc = 0;
  logic              deep_sleep = 0;
  logic              sys_reset_req;
  logic              wdt_irq;
  logic [2:0]        osc_phase = '0;
  logic              last_err;
  int                fails = 0;
  int                comparisons = 0;
  int                cycles = 0;
  int                resets = 0;
  int                irqs = 0;

  klw_watchdog #(.CNT_W(12)) i_klw_watchdog (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_speed_osc(low_speed_osc),
    .deep_sleep(deep_sleep), .sys_reset_req(sys_reset_req), .wdt_irq(wdt_irq)
  );

  initial begin
    forever #50 pclk = ~pclk; // config clock runs before any access
  end

  // oscillator locked to pclk so tick spacing is exact
  always @(posedge pclk) begin
    osc_phase <= osc_phase + 3'h1;
    low_speed_osc <= osc_phase[2];
    cycles++;
    if (sys_reset_req === 1'b1) resets++;
    if (wdt_irq === 1'b1) irqs++;
    if (cycles == 90000) begin
      fails++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the cycle ceiling ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    check(what, exp, r);
  endtask

  task automatic settle(input logic [31:0] mask);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      rd(OFS_STATUS, r);
      n++;
    end while ((r & mask) !== 32'h0 && n < 40);
    check("busy flags", 32'h0, r & mask);
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    wr(OFS_KEY, 32'h5555);
    wr(OFS_CTRL, v);
    settle(32'h1);
  endtask

  // read window spans exactly three tick periods
  task automatic measure(input int k);
    logic [31:0] c0;
    logic [31:0] c1;
    rd(OFS_COUNT, c0);
    repeat (3 * (32 << k) - 3) @(posedge pclk);
    rd(OFS_COUNT, c1);
    check("ticks in three periods", 32'h3, c0 - c1);
  endtask

  task automatic t_reset;
    logic [31:0] r;
    rd_chk("control", OFS_CTRL, 32'h0);
    rd_chk("reload", OFS_RELOAD, 32'hfff);
    rd_chk("window", OFS_WINDOW, 32'hfff);
    rd_chk("status", OFS_STATUS, 32'h0);
    wr(OFS_COUNT, 32'h0);
    rd_chk("count", OFS_COUNT, 32'hfff);
    rd(8'h40, r);
    check("unmapped error", 32'h1, {31'h0, last_err});
    wr(OFS_KEY, 32'h5555);
    wr(OFS_CTRL, 32'h3f);
    wr(OFS_RELOAD, 32'h5);
    rd_chk("control before start", OFS_CTRL, 32'h0);
    rd_chk("reload before start", OFS_RELOAD, 32'hfff);
    $display("test reset done");
  endtask

  task automatic t_start;
    logic [31:0] r;
    wr(OFS_KEY, 32'hcccc);
    rd(OFS_STATUS, r);
    check("running", 32'h1, {31'h0, r[ST_RUN]});
    measure(0);
    wr(OFS_RELOAD, 32'h3);
    rd_chk("reload while locked", OFS_RELOAD, 32'hfff);
    $display("test start done");
  endtask

  task automatic t_divider;
    for (int k = 0; k < 8; k++) begin
      set_ctrl(32'h8 | k);
      rd_chk("control", OFS_CTRL, 32'h8 | k);
      measure(k);
    end
    $display("test divider done");
  endtask

  task automatic t_overflow;
    logic [31:0] r;
    logic [31:0] c;
    int r0;
    // align so the second write lands while control is still crossing
    @(posedge low_speed_osc);
    repeat (2) @(posedge pclk);
    wr(OFS_KEY, 32'h5555);
    wr(OFS_CTRL, 32'h18);
    wr(OFS_CTRL, 32'h0);
    settle(32'h1);
    rd_chk("control while busy", OFS_CTRL, 32'h18);
    wr(OFS_KEY, 32'h5555);
    wr(OFS_RELOAD, 32'h3);
    settle(32'h3);
    rd_chk("reload", OFS_RELOAD, 32'h3);
    r0 = resets;
    wr(OFS_KEY, 32'haaaa);
    rd(OFS_COUNT, c);
    check("count after refresh", 32'h1, {31'h0, c <= 32'h3});
    settle(32'h20);
    repeat (200) @(posedge pclk);
    rd(OFS_STATUS, r);
    check("expiry flag", 32'h1, {31'h0, r[ST_EXP]});
    check("irq seen", 32'h1, {31'h0, irqs > 0});
    check("no reset", r0, resets);
    deep_sleep <= 1'b1;
    set_ctrl(32'h38);
    repeat (40) @(posedge pclk);
    wr(OFS_STATUS, 32'h0);
    rd(OFS_COUNT, c);
    repeat (300) @(posedge pclk);
    rd_chk("frozen count", OFS_COUNT, c);
    rd(OFS_STATUS, r);
    check("expiry cleared", 32'h0, {31'h0, r[ST_EXP]});
    check("irq low", 32'h0, {31'h0, wdt_irq});
    deep_sleep <= 1'b0;
    set_ctrl(32'h8);
    irqs = 0;
    repeat (300) @(posedge pclk);
    check("irq masked", 32'h0, irqs);
    check("no reset masked", r0, resets);
    set_ctrl(32'h0);
    repeat (300) @(posedge pclk);
    check("reset on expiry", 32'h1, {31'h0, resets > r0});
    set_ctrl(32'h8);
    $display("test overflow done");
  endtask

  task automatic t_window;
    logic [31:0] c;
    int r0;
    int n;
    wr(OFS_KEY, 32'h5555);
    wr(OFS_WINDOW, 32'h1);
    settle(32'h4);
    r0 = resets;
    wr(OFS_KEY, 32'haaaa);
    repeat (5) @(posedge pclk);
    check("early refresh reset", r0 + 1, resets);
    n = 0;
    do begin
      rd(OFS_COUNT, c);
      n++;
    end while (c !== 32'h1 && n < 100);
    check("count reaches window", 32'h1, c);
    r0 = resets;
    wr(OFS_KEY, 32'haaaa);
    repeat (5) @(posedge pclk);
    check("timely refresh", r0, resets);
    $display("test window done");
  endtask

  task automatic t_stop;
    logic [31:0] r;
    logic [31:0] c;
    wr(OFS_KEY, 32'h5a5a);
    wr(OFS_KEY, 32'haaaa);
    wr(OFS_KEY, 32'ha5a5);
    rd(OFS_STATUS, r);
    check("still running", 32'h1, {31'h0, r[ST_RUN]});
    wr(OFS_KEY, 32'h5a5a);
    rd(OFS_COUNT, c);
    wr(OFS_KEY, 32'ha5a5);
    rd(OFS_STATUS, r);
    check("stopped", 32'h0, {31'h0, r[ST_RUN]});
    rd(OFS_COUNT, c);
    repeat (300) @(posedge pclk);
    rd_chk("count held", OFS_COUNT, c);
    $display("test stop done");
  endtask

  task automatic summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_start();
    t_divider();
    t_overflow();
    t_window();
    t_stop();
    summarize();
  end
endmodule
